/* verilog/acl_pkg.sv */
// Constants and types for the armature current limiter
// Contract
// - Four limits, the lowest one wins
// - Prevailing positive and negative clamps are outputs
// - Absolute current limit bounds everything
// - External clamps: single or separate, both scaled
// - Profile cuts limit with speed between breakpoints
// - Overload allows up to 150 percent
// - Integrator fills above target, empties below
// - Full integrator ramps limit from 150 down
// - Sustained overload holds limit at target
// - Recovery gradual, full 150 only when empty
// - Capacity gives dwell (150-target)x25s/(current-target)
// - Reduction ramp at constant rate from ramp time
// - Software trip above 300 percent rated
// - Hardware trip above 150 percent model rating
// - Zero limit or zero target forces zero demand
// - Breakpoints under 10 percent apart get widened
// - Profile may rise as well as fall
// - Profile spans from 150, absolute limit prevails
// - Demand minus feedback into PI amplifier
// - PI output is phase angle demand
// - External limit is clamp input times scaler
// - Separate clamps crossed through zero give zero
// - Single clamp mode gives symmetric limits
package acl_pkg;
  typedef logic signed [15:0] acl_pct_t;
  localparam int        CLK_MHZ      = 250;
  localparam int        TICK_US      = 1000;
  localparam int        TICK_CYC     = CLK_MHZ * TICK_US;
  localparam int        DWELL_S      = 25;
  localparam int        DWELL_TICKS  = DWELL_S * 1000000 / TICK_US;
  localparam acl_pct_t  PCT_FULL     = 16'sh2710;
  localparam acl_pct_t  OL_MAX_PCT   = 16'sh3A98;
  localparam acl_pct_t  SW_TRIP_PCT  = 16'sh7530;
  localparam acl_pct_t  HW_TRIP_PCT  = 16'sh3A98;
  localparam acl_pct_t  PROF_GAP_PCT = 16'sh03E8;
  localparam acl_pct_t  PCT_POS_MAX  = 16'sh7FFF;
  localparam acl_pct_t  PCT_NEG_MAX  = -16'sh7FFF;
  localparam logic [31:0] RAMP_SPAN  = 32'h0000_2710;
  localparam int        GAIN_FRAC    = 8;
  typedef enum logic [1:0] {
    OL_HOLD    = 2'b00,
    OL_REDUCE  = 2'b01,
    OL_RECOVER = 2'b11
  } acl_ol_state_e;
endpackage

/* verilog/acl_overload_integ.sv */
// Overload integrator with saturating capacity
`timescale 1ns/1ns
module acl_overload_integ (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Sample tick and levels
  input  wire logic             tick,
  input  wire acl_pkg::acl_pct_t armMagnitude,
  input  wire acl_pkg::acl_pct_t olTarget,
  // Status
  output logic                  integFull,
  output logic                  integEmpty
);
  import acl_pkg::*;
  logic signed [33:0] integ_reg;
  logic signed [33:0] integ_next;
  logic signed [33:0] capacity;
  logic signed [33:0] sum;
  logic signed [16:0] delta;
  // Capacity scaled so dwell matches the formula
  assign capacity = 34'(OL_MAX_PCT - olTarget) * 34'(DWELL_TICKS);
  assign delta = 17'(armMagnitude) - 17'(olTarget);
  assign sum = integ_reg + 34'(delta);
  always_comb begin
    integ_next = integ_reg;
    if (tick) begin
      if (sum < 34'sh0)
        integ_next = 34'sh0;
      else if (sum > capacity)
        integ_next = capacity;
      else
        integ_next = sum;
    end
  end
  always_ff @(posedge clk) begin
    if (srst)
      integ_reg <= 34'sh0;
    else
      integ_reg <= integ_next;
  end
  assign integFull  = (integ_reg >= capacity);
  assign integEmpty = (integ_reg == 34'sh0);
endmodule

/* verilog/acl_current_pi.sv */
// Proportional plus integral current error amplifier
`timescale 1ns/1ns
module acl_current_pi (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Sample tick and signals
  input  wire logic              tick,
  input  wire acl_pkg::acl_pct_t demand,
  input  wire acl_pkg::acl_pct_t feedback,
  // Gains, 8 fraction bits
  input  wire logic [15:0]       propGain,
  input  wire logic [15:0]       intGain,
  // Phase angle demand
  output acl_pkg::acl_pct_t      phaseDemand
);
  import acl_pkg::*;
  logic signed [16:0] err;
  logic signed [33:0] pTerm;
  logic signed [33:0] iStep;
  logic signed [33:0] iSum;
  logic signed [33:0] total;
  acl_pct_t           integ_reg;
  acl_pct_t           integ_next;
  acl_pct_t           out_next;
  function automatic acl_pct_t sat16(input logic signed [33:0] v);
    if (v > 34'(PCT_POS_MAX))
      sat16 = PCT_POS_MAX;
    else if (v < 34'(PCT_NEG_MAX))
      sat16 = PCT_NEG_MAX;
    else
      sat16 = v[15:0];
  endfunction
  assign err   = 17'(demand) - 17'(feedback);
  assign pTerm = (34'(err) * $signed({18'h0, propGain})) >>> GAIN_FRAC;
  assign iStep = (34'(err) * $signed({18'h0, intGain})) >>> GAIN_FRAC;
  assign iSum  = 34'(integ_reg) + iStep;
  assign integ_next = sat16(iSum);
  assign total = pTerm + 34'(integ_next);
  assign out_next = sat16(total);
  always_ff @(posedge clk) begin
    if (srst) begin
      integ_reg   <= 16'sh0000;
      phaseDemand <= 16'sh0000;
    end else if (tick) begin
      integ_reg   <= integ_next;
      phaseDemand <= out_next;
    end
  end
endmodule

/* verilog/acl_current_limiter.sv */
// Armature current limiter: four clamps, overload, trips, PI
`timescale 1ns/1ns
module acl_current_limiter #(
  parameter int TICK_CYCLES = acl_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Reference and feedback
  input  wire acl_pkg::acl_pct_t currentRef,
  input  wire acl_pkg::acl_pct_t currentFeedback,
  input  wire acl_pkg::acl_pct_t modelCurrent,
  input  wire acl_pkg::acl_pct_t speedFeedback,
  // Absolute limit and overload settings
  input  wire acl_pkg::acl_pct_t currentLimit,
  input  wire acl_pkg::acl_pct_t overloadTarget,
  input  wire logic [15:0]       overloadRampTicks,
  // Speed current profile settings
  input  wire logic              profileEnable,
  input  wire acl_pkg::acl_pct_t profileSpeedHigh,
  input  wire acl_pkg::acl_pct_t profileSpeedLow,
  input  wire acl_pkg::acl_pct_t profileLowCurrent,
  // External clamps
  input  wire logic              separate_clamp_select,
  input  wire acl_pkg::acl_pct_t upper_external_clamp,
  input  wire acl_pkg::acl_pct_t lower_external_clamp,
  input  wire acl_pkg::acl_pct_t clamp_scale_factor,
  // Amplifier gains
  input  wire logic [15:0]       propGain,
  input  wire logic [15:0]       intGain,
  // Trip handling
  input  wire logic              tripClear,
  // Diagnostics and results
  output acl_pkg::acl_pct_t      posClampLevel,
  output acl_pkg::acl_pct_t      negClampLevel,
  output acl_pkg::acl_pct_t      overloadLimit,
  output acl_pkg::acl_pct_t      currentDemand,
  output acl_pkg::acl_pct_t      phaseAngleDemand,
  output logic                   softwareTrip,
  output logic                   hardwareTrip
);
  import acl_pkg::*;

  // Saturating helpers
  function automatic acl_pct_t sat16(input logic signed [33:0] v);
    if (v > 34'(PCT_POS_MAX))
      sat16 = PCT_POS_MAX;
    else if (v < 34'(PCT_NEG_MAX))
      sat16 = PCT_NEG_MAX;
    else
      sat16 = v[15:0];
  endfunction

  function automatic acl_pct_t pct_min(input acl_pct_t a, input acl_pct_t b);
    pct_min = (a < b) ? a : b;
  endfunction

  function automatic acl_pct_t pct_max(input acl_pct_t a, input acl_pct_t b);
    pct_max = (a > b) ? a : b;
  endfunction

  function automatic acl_pct_t pct_abs(input acl_pct_t a);
    pct_abs = sat16(34'(a) < 34'sh0 ? -34'(a) : 34'(a));
  endfunction

  function automatic acl_pct_t pct_scale(input acl_pct_t a, input acl_pct_t b);
    pct_scale = sat16((34'(a) * 34'(b)) / 34'(PCT_FULL));
  endfunction

  // Sample tick
  logic [31:0] tickCnt_reg;
  logic [31:0] tickCnt_next;
  logic        tick_reg;
  wire         tickWrap = (tickCnt_reg >= 32'(TICK_CYCLES - 1));

  assign tickCnt_next = tickWrap ? 32'h0 : tickCnt_reg + 32'h1;

  always_ff @(posedge clk) begin
    if (srst) begin
      tickCnt_reg <= 32'h0;
      tick_reg    <= 1'b0;
    end else begin
      tickCnt_reg <= tickCnt_next;
      tick_reg    <= tickWrap;
    end
  end

  // Magnitudes
  wire acl_pct_t armMag   = pct_abs(currentFeedback);
  wire acl_pct_t modelMag = pct_abs(modelCurrent);
  wire acl_pct_t speedMag = pct_abs(speedFeedback);
  wire acl_pct_t absLimit = pct_max(pct_min(currentLimit, PCT_POS_MAX), 16'sh0000);
  wire acl_pct_t olTarget = pct_min(pct_max(overloadTarget, 16'sh0000), OL_MAX_PCT);

  // Overload integrator
  logic integFull;
  logic integEmpty;

  acl_overload_integ u_integ (
    .clk          (clk),
    .srst         (srst),
    .tick         (tick_reg),
    .armMagnitude (armMag),
    .olTarget     (olTarget),
    .integFull    (integFull),
    .integEmpty   (integEmpty)
  );

  // Overload limit ramp
  acl_ol_state_e olState_reg;
  acl_ol_state_e olState_next;
  acl_pct_t      olLimit_reg;
  acl_pct_t      olLimit_next;
  logic [31:0]   rampAcc_reg;
  logic [31:0]   rampAcc_next;
  wire  [31:0]   rampTime = {16'h0, overloadRampTicks};
  wire  [31:0]   rampAccIn = tick_reg ? rampAcc_reg + RAMP_SPAN : rampAcc_reg;
  wire           rampStep = (rampTime == 32'h0) || (rampAccIn >= rampTime);
  wire  [31:0]   rampAccLeft = (rampTime == 32'h0) ? 32'h0 : rampAccIn - rampTime;
  wire acl_pct_t recoverCap = OL_MAX_PCT - 16'sh0001;

  always_comb begin
    olState_next = olState_reg;
    case (olState_reg)
      OL_HOLD: begin
        if (integFull)
          olState_next = OL_REDUCE;
      end
      OL_REDUCE: begin
        if (!integFull)
          olState_next = OL_RECOVER;
      end
      OL_RECOVER: begin
        if (integFull)
          olState_next = OL_REDUCE;
        else if (integEmpty)
          olState_next = OL_HOLD;
      end
      default: olState_next = OL_HOLD;
    endcase
  end

  always_comb begin
    olLimit_next = olLimit_reg;
    rampAcc_next = 32'h0;
    case (olState_reg)
      OL_HOLD: begin
        olLimit_next = OL_MAX_PCT;
        if (integFull)
          olLimit_next = OL_MAX_PCT;
      end
      OL_REDUCE: begin
        if (olLimit_reg > olTarget) begin
          rampAcc_next = rampAccIn;
          if (rampStep) begin
            olLimit_next = olLimit_reg - 16'sh0001;
            rampAcc_next = rampAccLeft;
          end
        end else begin
          olLimit_next = olTarget;
        end
      end
      OL_RECOVER: begin
        if (integEmpty) begin
          olLimit_next = OL_MAX_PCT;
        end else if (olLimit_reg < recoverCap) begin
          rampAcc_next = rampAccIn;
          if (rampStep) begin
            olLimit_next = olLimit_reg + 16'sh0001;
            rampAcc_next = rampAccLeft;
          end
        end else begin
          olLimit_next = recoverCap;
        end
      end
      default: olLimit_next = OL_MAX_PCT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      olState_reg <= OL_HOLD;
      olLimit_reg <= OL_MAX_PCT;
      rampAcc_reg <= 32'h0;
    end else begin
      olState_reg <= olState_next;
      olLimit_reg <= olLimit_next;
      rampAcc_reg <= rampAcc_next;
    end
  end

  // Speed current profile breakpoints
  wire acl_pct_t bpHigh = pct_max(profileSpeedHigh, 16'sh0000);
  wire acl_pct_t bpLow  = pct_max(profileSpeedLow, 16'sh0000);
  wire           lowFirst = (bpLow < bpHigh);
  wire acl_pct_t spdA = lowFirst ? bpLow : bpHigh;
  wire acl_pct_t spdBRaw = lowFirst ? bpHigh : bpLow;
  wire acl_pct_t curA = lowFirst ? profileLowCurrent : OL_MAX_PCT;
  wire acl_pct_t curB = lowFirst ? OL_MAX_PCT : profileLowCurrent;
  wire           gapShort = (34'(spdBRaw) - 34'(spdA)) < 34'(PROF_GAP_PCT);
  wire acl_pct_t spdB = gapShort ? sat16(34'(spdA) + 34'(PROF_GAP_PCT)) : spdBRaw;

  // Linear interpolation between the breakpoints
  wire logic signed [33:0] spanSpd = 34'(spdB) - 34'(spdA);
  wire logic signed [33:0] offSpd  = 34'(speedMag) - 34'(spdA);
  wire logic signed [33:0] spanCur = 34'(curB) - 34'(curA);
  wire logic signed [33:0] interp  = 34'(curA) + (spanCur * offSpd) / spanSpd;
  acl_pct_t profRaw;

  always_comb begin
    if (!profileEnable)
      profRaw = OL_MAX_PCT;
    else if (speedMag <= spdA)
      profRaw = curA;
    else if (speedMag >= spdB)
      profRaw = curB;
    else
      profRaw = sat16(interp);
  end

  acl_pct_t profLimit_reg;

  always_ff @(posedge clk) begin
    if (srst)
      profLimit_reg <= OL_MAX_PCT;
    else
      profLimit_reg <= pct_max(profRaw, 16'sh0000);
  end

  // External clamps
  wire acl_pct_t extUpper = pct_scale(upper_external_clamp, clamp_scale_factor);
  wire acl_pct_t extLowerSep = pct_scale(lower_external_clamp, clamp_scale_factor);
  wire acl_pct_t extUpperNeg = sat16(-34'(extUpper));
  wire acl_pct_t extLower = separate_clamp_select ? extLowerSep : extUpperNeg;
  wire           crossed = separate_clamp_select && (extUpper < 16'sh0000) && (extLower > 16'sh0000);

  // Combine the four limits
  wire acl_pct_t magLimit3 = pct_min(pct_min(absLimit, olLimit_reg), profLimit_reg);
  wire acl_pct_t negLimit3 = sat16(-34'(magLimit3));
  wire           forceZero = (absLimit == 16'sh0000) || (olTarget == 16'sh0000);
  wire acl_pct_t posLim = pct_min(magLimit3, extUpper);
  wire acl_pct_t negLim = pct_max(negLimit3, extLower);
  wire acl_pct_t posClampNext = (forceZero || crossed) ? 16'sh0000 : posLim;
  wire acl_pct_t negClampNext = (forceZero || crossed) ? 16'sh0000 : negLim;

  // Clamp the reference; crossed limits let the nearer clamp lead
  wire acl_pct_t demandPosRegion = pct_min(pct_max(currentRef, negClampNext), posClampNext);
  wire acl_pct_t demandNegRegion = pct_max(pct_min(currentRef, posClampNext), negClampNext);
  wire acl_pct_t demandNext = (posClampNext >= 16'sh0000) ? demandPosRegion : demandNegRegion;

  always_ff @(posedge clk) begin
    if (srst) begin
      posClampLevel <= 16'sh0000;
      negClampLevel <= 16'sh0000;
      currentDemand <= 16'sh0000;
      overloadLimit <= OL_MAX_PCT;
    end else begin
      posClampLevel <= posClampNext;
      negClampLevel <= negClampNext;
      currentDemand <= demandNext;
      overloadLimit <= olLimit_reg;
    end
  end

  // Overcurrent trips, held until cleared
  wire swOver = (armMag > SW_TRIP_PCT);
  wire hwOver = (modelMag > HW_TRIP_PCT);

  always_ff @(posedge clk) begin
    if (srst) begin
      softwareTrip <= 1'b0;
      hardwareTrip <= 1'b0;
    end else begin
      softwareTrip <= swOver || (softwareTrip && !tripClear);
      hardwareTrip <= hwOver || (hardwareTrip && !tripClear);
    end
  end

  // Current error amplifier
  acl_current_pi u_pi (
    .clk         (clk),
    .srst        (srst),
    .tick        (tick_reg),
    .demand      (currentDemand),
    .feedback    (currentFeedback),
    .propGain    (propGain),
    .intGain     (intGain),
    .phaseDemand (phaseAngleDemand)
  );
endmodule

/* verification/acl_limiter_monitor.sv */
// Assertion checker for the armature current limiter
`timescale 1ns/1ns
module acl_limiter_monitor (
  // Clock and reset
  input wire logic              clk,
  input wire logic              srst,
  // Inputs watched
  input wire acl_pkg::acl_pct_t currentFeedback,
  input wire acl_pkg::acl_pct_t modelCurrent,
  input wire acl_pkg::acl_pct_t currentLimit,
  input wire acl_pkg::acl_pct_t overloadTarget,
  input wire logic              separate_clamp_select,
  input wire acl_pkg::acl_pct_t upper_external_clamp,
  input wire acl_pkg::acl_pct_t lower_external_clamp,
  input wire logic              tripClear,
  // Outputs watched
  input wire acl_pkg::acl_pct_t posClampLevel,
  input wire acl_pkg::acl_pct_t negClampLevel,
  input wire acl_pkg::acl_pct_t overloadLimit,
  input wire acl_pkg::acl_pct_t currentDemand,
  input wire logic              softwareTrip,
  input wire logic              hardwareTrip
);
  import acl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_DEM_IN_CLAMPS: assert property (posClampLevel >= negClampLevel |->
    currentDemand <= posClampLevel && currentDemand >= negClampLevel) else $error("demand outside clamps");
  AST_POS_ABS: assert property (posClampLevel <= $past(currentLimit)) else $error("pos clamp above limit");
  AST_NEG_ABS: assert property (negClampLevel >= -$past(currentLimit)) else $error("neg clamp below limit");
  AST_ZERO_FORCE: assert property ((currentLimit == 16'sh0000 || overloadTarget == 16'sh0000) |=>
    currentDemand == 16'sh0000 && posClampLevel == 16'sh0000) else $error("zero setting not forcing zero");
  AST_CROSSED: assert property (separate_clamp_select && upper_external_clamp < 0 &&
    lower_external_clamp > 0 |=> currentDemand == 16'sh0000) else $error("crossed clamps not zero");
  AST_OL_CEIL: assert property (overloadLimit <= OL_MAX_PCT) else $error("overload limit above ceiling");
  AST_OL_STEP: assert property ($changed(overloadLimit) |->
    (overloadLimit - $past(overloadLimit) == 16'sh0001 || $past(overloadLimit) - overloadLimit == 16'sh0001))
    else $error("overload limit jumped");
  AST_SW_TRIP: assert property ((currentFeedback > SW_TRIP_PCT || currentFeedback < -SW_TRIP_PCT) |=>
    softwareTrip) else $error("software trip missing");
  AST_HW_TRIP: assert property ((modelCurrent > HW_TRIP_PCT || modelCurrent < -HW_TRIP_PCT) |=>
    hardwareTrip) else $error("hardware trip missing");
  AST_SW_HOLD: assert property (softwareTrip && !tripClear |=> softwareTrip) else $error("software trip lost");
  AST_HW_HOLD: assert property ($fell(hardwareTrip) |-> $past(tripClear)) else $error("hardware trip lost");

  cover property (softwareTrip && hardwareTrip);
  cover property (overloadLimit == overloadTarget && overloadTarget != 16'sh0000);
  cover property (separate_clamp_select && upper_external_clamp < 0 && lower_external_clamp > 0);
endmodule

bind acl_current_limiter acl_limiter_monitor mon (.clk, .srst, .currentFeedback, .modelCurrent, .currentLimit,
  .overloadTarget, .separate_clamp_select, .upper_external_clamp, .lower_external_clamp, .tripClear,
  .posClampLevel, .negClampLevel, .overloadLimit, .currentDemand, .softwareTrip, .hardwareTrip);

/* verification/acl_drive_model.sv */
// Speed loop and armature current source facing the limiter
`timescale 1ns/1ns
module acl_drive_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Bench commands
  input  wire acl_pkg::acl_pct_t refCmd,
  input  wire acl_pkg::acl_pct_t feedCmd,
  // Limiter side
  output acl_pkg::acl_pct_t      currentRef,
  output acl_pkg::acl_pct_t      currentFeedback
);
  import acl_pkg::*;
  always_ff @(posedge clk) begin
    if (srst) begin
      currentRef      <= 16'sh0000;
      currentFeedback <= 16'sh0000;
    end else begin
      currentRef      <= refCmd;
      currentFeedback <= feedCmd;
    end
  end
endmodule

/* verification/tb_armature_current_limiter.sv */
// Self-checking bench for the armature current limiter
`timescale 1ns/1ns
module tb_armature_current_limiter;
  import acl_pkg::*;
  localparam int TICKS = 10;
  logic        clk = 1'b0, srst = 1'b1, profileEnable = 1'b0, separate_clamp_select = 1'b0, tripClear = 1'b0;
  acl_pct_t    refCmd = '0, feedCmd = '0, modelCurrent = '0, speedFeedback = '0;
  acl_pct_t    currentLimit = 16'sh3A98, overloadTarget = 16'sh36B0;
  acl_pct_t    profileSpeedHigh = '0, profileSpeedLow = '0, profileLowCurrent = '0;
  acl_pct_t    upper_external_clamp = 16'sh3A98, lower_external_clamp = -16'sh3A98, clamp_scale_factor = 16'sh2710;
  logic [15:0] overloadRampTicks = 16'h0000, propGain = 16'h0100, intGain = 16'h0000;
  acl_pct_t    currentRef, currentFeedback, posClampLevel, negClampLevel, overloadLimit, currentDemand;
  acl_pct_t    phaseAngleDemand;
  logic        softwareTrip, hardwareTrip;
  int          num_errors = 0, compares = 0;

  always #2 clk = ~clk;

  acl_drive_model drv (.clk, .srst, .refCmd, .feedCmd, .currentRef, .currentFeedback);
  acl_current_limiter #(.TICK_CYCLES(TICKS)) uut (.clk, .srst, .currentRef, .currentFeedback, .modelCurrent,
    .speedFeedback, .currentLimit, .overloadTarget, .overloadRampTicks, .profileEnable, .profileSpeedHigh,
    .profileSpeedLow, .profileLowCurrent, .separate_clamp_select, .upper_external_clamp, .lower_external_clamp,
    .clamp_scale_factor, .propGain, .intGain, .tripClear, .posClampLevel, .negClampLevel, .overloadLimit,
    .currentDemand, .phaseAngleDemand, .softwareTrip, .hardwareTrip);

  task automatic chk(input acl_pct_t act, input acl_pct_t exp);
    compares++;
    if (act !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0d expected %0d", $time, act, exp);
    end
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clamp_case(input logic sep, input acl_pct_t rf, up, lo, sc, ePos, eNeg, eDem);
    @(posedge clk);
    separate_clamp_select <= sep;
    refCmd <= rf;
    upper_external_clamp <= up;
    lower_external_clamp <= lo;
    clamp_scale_factor <= sc;
    go(4);
    chk(posClampLevel, ePos);
    chk(negClampLevel, eNeg);
    chk(currentDemand, eDem);
  endtask

  task automatic prof_case(input acl_pct_t hi, lo, spd, lim, ePos);
    @(posedge clk);
    profileEnable <= 1'b1;
    profileSpeedHigh <= hi;
    profileSpeedLow <= lo;
    profileLowCurrent <= 16'sh1388;
    speedFeedback <= spd;
    currentLimit <= lim;
    go(5);
    chk(posClampLevel, ePos);
  endtask

  task automatic final_report();
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(4 * 80000);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    go(2);
    chk(overloadLimit, OL_MAX_PCT);
    clamp_case(1'b0, 16'sh4E20, 16'sh3A98, -16'sh3A98, 16'sh2710, 16'sh3A98, -16'sh3A98, 16'sh3A98);
    clamp_case(1'b0, -16'sh4E20, 16'sh3A98, -16'sh3A98, 16'sh2710, 16'sh3A98, -16'sh3A98, -16'sh3A98);
    clamp_case(1'b0, 16'sh4E20, 16'sh1388, -16'sh3A98, 16'sh1388, 16'sh09C4, -16'sh09C4, 16'sh09C4);
    clamp_case(1'b1, -16'sh4E20, 16'sh1F40, -16'sh0BB8, 16'sh2710, 16'sh1F40, -16'sh0BB8, -16'sh0BB8);
    clamp_case(1'b1, 16'sh1388, -16'sh07D0, 16'sh0BB8, 16'sh2710, 16'sh0000, 16'sh0000, 16'sh0000);
    clamp_case(1'b1, -16'sh1388, 16'sh07D0, 16'sh0BB8, 16'sh2710, 16'sh07D0, 16'sh0BB8, 16'sh07D0);
    clamp_case(1'b0, 16'sh4E20, 16'sh7FFF, -16'sh3A98, 16'sh7FFF, 16'sh3A98, -16'sh3A98, 16'sh3A98);
    clamp_case(1'b0, 16'sh4E20, 16'sh3A98, -16'sh3A98, 16'sh2710, 16'sh3A98, -16'sh3A98, 16'sh3A98);
    @(posedge clk);
    currentLimit <= 16'sh0000;
    go(3);
    chk(currentDemand, 16'sh0000);
    currentLimit <= 16'sh3A98;
    overloadTarget <= 16'sh0000;
    go(3);
    chk(currentDemand, 16'sh0000);
    overloadTarget <= 16'sh36B0;
    prof_case(16'sh07D0, 16'sh1F40, 16'sh1388, 16'sh3A98, 16'sh2710);
    prof_case(16'sh07D0, 16'sh1F40, -16'sh2710, 16'sh3A98, 16'sh1388);
    prof_case(16'sh1F40, 16'sh07D0, 16'sh0000, 16'sh3A98, 16'sh1388);
    prof_case(16'sh1F40, 16'sh07D0, 16'sh1388, 16'sh3A98, 16'sh2710);
    prof_case(16'sh1388, 16'sh157C, 16'sh157C, 16'sh3A98, 16'sh2710);
    prof_case(16'sh07D0, 16'sh1F40, 16'sh0000, 16'sh2EE0, 16'sh2EE0);
    prof_case(16'sh07D0, 16'sh1F40, 16'sh1388, 16'sh2EE0, 16'sh2710);
    profileEnable <= 1'b0;
    currentLimit <= 16'sh3A98;
    feedCmd <= 16'sh7530;
    modelCurrent <= 16'sh3A98;
    go(4);
    chk(16'(softwareTrip), 16'sh0000);
    chk(16'(hardwareTrip), 16'sh0000);
    feedCmd <= -16'sh7531;
    modelCurrent <= -16'sh3A99;
    go(4);
    feedCmd <= 16'sh0000;
    modelCurrent <= 16'sh0000;
    go(4);
    chk(16'(softwareTrip), 16'sh0001);
    chk(16'(hardwareTrip), 16'sh0001);
    tripClear <= 1'b1;
    go(3);
    chk(16'(softwareTrip), 16'sh0000);
    chk(16'(hardwareTrip), 16'sh0000);
    tripClear <= 1'b0;
    refCmd <= 16'sh03E8;
    go(3 * TICKS);
    chk(phaseAngleDemand, 16'sh03E8);
    propGain <= 16'h0200;
    feedCmd <= 16'sh0BB8;
    go(3 * TICKS);
    chk(phaseAngleDemand, -16'sh0FA0);
    intGain <= 16'h0100;
    go(20 * TICKS);
    chk(phaseAngleDemand, PCT_NEG_MAX);
    intGain <= 16'h0000;
    propGain <= 16'h0100;
    overloadRampTicks <= 16'h03E8;
    refCmd <= 16'sh4E20;
    feedCmd <= 16'sh7148;
    go(14000);
    chk(overloadLimit, OL_MAX_PCT);
    go(6000);
    chk(overloadLimit, 16'sh36B0);
    chk(currentDemand, 16'sh36B0);
    feedCmd <= 16'sh0000;
    go(5000);
    chk(overloadLimit, 16'sh3A97);
    go(20000);
    chk(overloadLimit, OL_MAX_PCT);
    final_report();
  end
endmodule
